// [rfs_host_model.sv]
// Host-side AXI4-Lite master model for the status bank
`timescale 1ns/100ps
module rfs_host_model (
	input wire aclk,
	output reg [7:0] s_axi_awaddr,
	output reg s_axi_awvalid,
	input wire s_axi_awready,
	output reg [31:0] s_axi_wdata,
	output reg [3:0] s_axi_wstrb,
	output reg s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	output reg s_axi_bready,
	output reg [7:0] s_axi_araddr,
	output reg s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	output reg s_axi_rready
);
	initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = 0;
	initial {s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
	// Released payloads are inverted so a stale value cannot pass
	task rd(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task wr(input [7:0] a, input [31:0] d, output [1:0] r);
		reg aw;
		reg w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
endmodule

// [rfs_regs.vh]
// Register offsets, field positions and reset values of the fault and output status bank
`ifndef RFS_REGS_VH
`define RFS_REGS_VH

// ----------------------------------------------------------------
// Printed register indices (not all multiples of four)
// ----------------------------------------------------------------
`define RFS_IDX_FAULT 8'h10
`define RFS_IDX_ANGLE 8'h11
`define RFS_IDX_VELOCITY 8'h12
`define RFS_IDX_IRQ_MASK 8'h20
`define RFS_IDX_CONTROL 8'h21

// ----------------------------------------------------------------
// Fault register bit positions
// ----------------------------------------------------------------
`define RFS_B_EXC_MON_HIGH 15
`define RFS_B_EXC_MON_LOW 14
`define RFS_B_SERIAL_ERR 13
`define RFS_B_BOOST_OV 12
`define RFS_B_CORE_OC 11
`define RFS_B_THERMAL 10
`define RFS_B_EXC_DISABLED 9
`define RFS_B_ABIST_FAIL 8
`define RFS_B_LBIST_FAIL 7
`define RFS_B_MAIN_OV 6
`define RFS_B_CORE_OV 5
`define RFS_B_PIN_MISMATCH 4
`define RFS_B_ALARM_PIN 3
`define RFS_B_ENC_A 2
`define RFS_B_ENC_B 1
`define RFS_B_ENC_Z 0

// Bits cleared by a read of the fault register
`define RFS_FAULT_RC_MASK 16'hfc71
// Angle and velocity register fields
`define RFS_B_PARITY 14
`define RFS_B_OUT_CLOCK 13
`define RFS_ANGLE_10BIT_MASK 13'h03ff
`define RFS_ANGLE_12BIT_MASK 13'h0fff
// Exciter mode code that disables the exciter
`define RFS_EXC_MODE_OFF 2'b11
`define RFS_RESET_VALUE 16'h0000
`define RFS_AXI_OKAY 2'b00
`define RFS_AXI_SLVERR 2'b10

`endif

// [rfs_status_bank.v]
// Fault, angle and velocity status registers behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "rfs_regs.vh"

module rfs_status_bank (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire exciter_sense_input_1,
	input wire exciter_sense_input_2,
	input wire exc_high_fault,
	input wire exc_low_fault,
	input wire serial_fault,
	input wire boost_ov_fault,
	input wire core_oc_fault,
	input wire thermal_warn,
	input wire [1:0] exciter_mode_control,
	input wire abist_running,
	input wire abist_done,
	input wire abist_pass,
	input wire diagnostic_exit_command,
	input wire lbist_done,
	input wire lbist_pass,
	input wire main_ov_fault,
	input wire core_ov_fault,
	input wire pin_mismatch,
	input wire alarm_pin,
	input wire encoder_a_pin,
	input wire encoder_b_pin,
	input wire encoder_z_pin,
	input wire [13:0] parallel_output_bus,
	input wire parallel_output_clock_level,
	input wire [13:0] velocity_in,
	input wire res_12bit,
	output reg irq
);

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [15:0] live_q;
reg [15:0] live_d;
wire [15:0] sticky_q;
wire [15:0] fault_q;
reg [15:0] mask_q;
reg [15:0] angle_q;
reg [15:0] velocity_q;
reg [7:0] awaddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg aw_have_q;
reg w_have_q;
reg [31:0] rdata_d;
reg rresp_bad;
wire rd_fault;
reg [12:0] angle_mask;
reg [13:0] vel_val;
wire [7:0] ar_idx;
wire [7:0] aw_idx;
wire do_write;
wire do_read;
wire out_parity;

assign ar_idx = {2'b00, s_axi_araddr[7:2]};
assign aw_idx = {2'b00, awaddr_q[7:2]};
assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
assign do_read = s_axi_arvalid && s_axi_arready;
// Even parity across the output bus
assign out_parity = ^parallel_output_bus;

// ----------------------------------------------------------------
// Fault flag next value
// ----------------------------------------------------------------
assign rd_fault = do_read && (ar_idx == `RFS_IDX_FAULT);
assign fault_q = live_q | sticky_q;
// Positions that hold no read-clear flag
assign sticky_q[9:7] = 3'b000;
assign sticky_q[3:1] = 3'b000;

always @* begin
	live_d = `RFS_RESET_VALUE;
	live_d[`RFS_B_EXC_DISABLED] = (exciter_mode_control == `RFS_EXC_MODE_OFF);
	// Self-test flags ignore reads; only a rerun result, or for ABIST a diagnostic exit while running, changes them
	live_d[`RFS_B_ABIST_FAIL] = live_q[`RFS_B_ABIST_FAIL];
	if (abist_done) begin
		live_d[`RFS_B_ABIST_FAIL] = !abist_pass;
	end
	if (diagnostic_exit_command && abist_running) begin
		live_d[`RFS_B_ABIST_FAIL] = 1'b1;
	end
	live_d[`RFS_B_LBIST_FAIL] = live_q[`RFS_B_LBIST_FAIL];
	if (lbist_done) begin
		live_d[`RFS_B_LBIST_FAIL] = !lbist_pass;
	end
	// Live pin monitors
	live_d[`RFS_B_ALARM_PIN] = alarm_pin;
	live_d[`RFS_B_ENC_A] = encoder_a_pin;
	live_d[`RFS_B_ENC_B] = encoder_b_pin;
end

// ----------------------------------------------------------------
// Read-clear fault flags
// ----------------------------------------------------------------
rfs_sticky_bit u_exc_high (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(exc_high_fault && (exciter_sense_input_1 || exciter_sense_input_2)),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_EXC_MON_HIGH])
);

rfs_sticky_bit u_exc_low (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(exc_low_fault),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_EXC_MON_LOW])
);

rfs_sticky_bit u_serial (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(serial_fault),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_SERIAL_ERR])
);

rfs_sticky_bit u_boost_ov (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(boost_ov_fault),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_BOOST_OV])
);

rfs_sticky_bit u_core_oc (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(core_oc_fault),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_CORE_OC])
);

rfs_sticky_bit u_thermal (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(thermal_warn),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_THERMAL])
);

rfs_sticky_bit u_main_ov (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(main_ov_fault),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_MAIN_OV])
);

rfs_sticky_bit u_core_ov (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(core_ov_fault),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_CORE_OV])
);

rfs_sticky_bit u_pin_mismatch (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(pin_mismatch),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_PIN_MISMATCH])
);

// Z is held until read so short index pulses are seen
rfs_sticky_bit u_enc_z (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.set_evt(encoder_z_pin),
	.clr_rd(rd_fault),
	.flag_q(sticky_q[`RFS_B_ENC_Z])
);

// ----------------------------------------------------------------
// Sampled output values and interrupt
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		angle_q <= `RFS_RESET_VALUE;
		velocity_q <= `RFS_RESET_VALUE;
	end else if (clk_en) begin
		angle_q <= {1'b0, out_parity, parallel_output_clock_level,
			parallel_output_bus[12:0] & angle_mask & 13'h0fff};
		velocity_q <= {1'b0, out_parity, vel_val};
	end
end

// Level interrupt; follows the visible flags enabled in mask_q one cycle later
always @(posedge aclk) begin
	if (!aresetn) begin
		irq <= 1'b0;
	end else if (clk_en) begin
		irq <= |(fault_q & mask_q);
	end
end

// ----------------------------------------------------------------
// Output value formatting
// ----------------------------------------------------------------
always @* begin
	angle_mask = res_12bit ? `RFS_ANGLE_12BIT_MASK : `RFS_ANGLE_10BIT_MASK;
	// Sign extension keeps upper bits sane; reader still ignores them
	if (res_12bit) begin
		vel_val = {{2{velocity_in[11]}}, velocity_in[11:0]};
	end else begin
		vel_val = {{4{velocity_in[9]}}, velocity_in[9:0]};
	end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @* begin
	rdata_d = 32'h0000_0000;
	rresp_bad = 1'b0;
	case (ar_idx)
		`RFS_IDX_FAULT: rdata_d = {16'h0000, fault_q};
		`RFS_IDX_ANGLE: rdata_d = {16'h0000, angle_q};
		`RFS_IDX_VELOCITY: rdata_d = {16'h0000, velocity_q};
		`RFS_IDX_IRQ_MASK: rdata_d = {16'h0000, mask_q};
		`RFS_IDX_CONTROL: rdata_d = 32'h0000_0000;
		default: rresp_bad = 1'b1;
	endcase
end

// ----------------------------------------------------------------
// Registers and bus slave
// ----------------------------------------------------------------
always @(posedge aclk) begin
	if (!aresetn) begin
		live_q <= `RFS_RESET_VALUE;
		mask_q <= `RFS_RESET_VALUE;
		awaddr_q <= 8'h00;
		wdata_q <= 32'h0000_0000;
		wstrb_q <= 4'h0;
		aw_have_q <= 1'b0;
		w_have_q <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RFS_AXI_OKAY;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `RFS_AXI_OKAY;
	end else if (clk_en) begin
		live_q <= live_d;
		// Write channels taken independently, one outstanding
		s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
		s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_q <= s_axi_awaddr;
			aw_have_q <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
			w_have_q <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (do_write) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `RFS_AXI_OKAY;
			if (aw_idx == `RFS_IDX_IRQ_MASK) begin
				if (wstrb_q[0]) begin
					mask_q[7:0] <= wdata_q[7:0];
				end
				if (wstrb_q[1]) begin
					mask_q[15:8] <= wdata_q[15:8];
				end
			end else if (aw_idx != `RFS_IDX_CONTROL && aw_idx != `RFS_IDX_FAULT &&
				aw_idx != `RFS_IDX_ANGLE && aw_idx != `RFS_IDX_VELOCITY) begin
				s_axi_bresp <= `RFS_AXI_SLVERR;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		// Read: one outstanding, data registered with the handshake
		s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
		if (do_read) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdata_d;
			s_axi_rresp <= rresp_bad ? `RFS_AXI_SLVERR : `RFS_AXI_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

// ----------------------------------------------------------------
// One read-clear fault flag
// ----------------------------------------------------------------
module rfs_sticky_bit #(
	parameter [0:0] INIT_VALUE = 1'b0
) (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire set_evt,
	input wire clr_rd,
	output reg flag_q
);

always @(posedge aclk) begin
	if (!aresetn) begin
		flag_q <= INIT_VALUE;
	end else if (clk_en) begin
		// Set beats a same-cycle clearing read so no event is lost
		if (set_evt) begin
			flag_q <= 1'b1;
		end else if (clr_rd) begin
			flag_q <= 1'b0;
		end
	end
end

endmodule

// [rfs_status_bank_bench.sv]
// Self-checking bench for the fault and output status bank
`timescale 1ns/100ps
`include "rfs_regs.vh"
module rfs_status_bank_bench;
	localparam [7:0] AF = `RFS_IDX_FAULT * 4;
	localparam [7:0] AA = `RFS_IDX_ANGLE * 4;
	localparam [7:0] AV = `RFS_IDX_VELOCITY * 4;
	localparam [7:0] AM = `RFS_IDX_IRQ_MASK * 4;
	reg aclk = 0;
	reg aresetn = 0;
	reg [15:0] ev = 0;
	reg [5:0] bist = 0;
	reg [1:0] mode = 0;
	reg [13:0] bus = 0;
	reg [13:0] vel = 0;
	reg oclk = 0;
	reg res = 0;
	reg ce = 1;
	wire [7:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0] s_axi_wstrb;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, irq;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int fail_count = 0;
	int n_compared = 0;
	logic [33:0] q[$];
	logic [1:0] br;
	logic [31:0] r;
	logic [13:0] ex;
	logic [12:0] m;
	logic [21:0] bt [5] = '{22'h120180, 22'h000180, 22'h1b0000, 22'h240100, 22'h180000};
	rfs_host_model host (.*);
	rfs_status_bank uut (.*, .clk_en(ce), .exciter_sense_input_1(1'b1), .exciter_sense_input_2(1'b0),
		.exc_high_fault(ev[15]), .exc_low_fault(ev[14]), .serial_fault(ev[13]), .boost_ov_fault(ev[12]),
		.core_oc_fault(ev[11]), .thermal_warn(ev[10]), .main_ov_fault(ev[6]), .core_ov_fault(ev[5]),
		.pin_mismatch(ev[4]), .alarm_pin(ev[3]), .encoder_a_pin(ev[2]), .encoder_b_pin(ev[1]),
		.encoder_z_pin(ev[0]), .exciter_mode_control(mode), .abist_running(bist[5]), .abist_done(bist[4]),
		.abist_pass(bist[3]), .diagnostic_exit_command(bist[2]), .lbist_done(bist[1]), .lbist_pass(bist[0]),
		.parallel_output_bus(bus), .parallel_output_clock_level(oclk), .velocity_in(vel), .res_12bit(res));
	task chk(input [39:0] nm, input [33:0] e, input [33:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task rx(input [7:0] a, input [33:0] e);
		q.push_back(e);
		host.rd(a);
	endtask
	task hit(input [15:0] v);
		ev <= v;
		cyc(1);
		ev <= 0;
		cyc(3);
	endtask
	task report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial forever #50 aclk = ~aclk;
	// Whole sequence needs well under a thousand cycles
	initial begin
		#1000000;
		fail_count++;
		report_and_stop;
	end
	always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
	initial begin
		void'($urandom(32'h4f17));
		cyc(3);
		aresetn <= 1'b1;
		rx(AF, 0);
		rx(AA, 0);
		rx(AV, 0);
		hit(16'hfc7f);
		rx(AF, 16'hfc71);
		rx(AF, 0);
		ev <= 16'h000e;
		cyc(3);
		rx(AF, 16'h000e);
		rx(AF, 16'h000e);
		for (int i = 0; i < 4; i++) begin
			mode <= i[1:0];
			cyc(3);
			rx(AF, {6'h00, i[1:0] == `RFS_EXC_MODE_OFF, 5'h00, ev[3:0]});
		end
		mode <= 0;
		ev <= 16'h4000;
		cyc(2);
		rx(AF, 16'h4000);
		ev <= 0;
		rx(AF, 16'h4000);
		rx(AF, 0);
		for (int i = 0; i < 5; i++) begin
			bist <= bt[i][21:16];
			cyc(1);
			bist <= 0;
			cyc(2);
			rx(AF, bt[i][15:0]);
		end
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			{res, oclk, bus} <= r[15:0];
			vel <= r[29:16];
			cyc(3);
			m = res ? `RFS_ANGLE_12BIT_MASK : `RFS_ANGLE_10BIT_MASK;
			rx(AA, {1'b0, ^bus, oclk, bus[12:0] & m});
			ex = res ? {{2{vel[11]}}, vel[11:0]} : {{4{vel[9]}}, vel[9:0]};
			rx(AV, {1'b0, ^bus, ex});
		end
		host.wr(AF, 32'hffff, br);
		chk("bresp", `RFS_AXI_OKAY, br);
		rx(AF, 0);
		host.wr(8'h4c, 0, br);
		chk("bresp", `RFS_AXI_SLVERR, br);
		rx(8'h4c, {`RFS_AXI_SLVERR, 32'h0});
		host.wr(AM, 32'h4000, br);
		hit(16'h4000);
		chk("irq", 1, irq);
		rx(AF, 16'h4000);
		cyc(3);
		chk("irq", 0, irq);
		host.wr(AM, 0, br);
		hit(16'h4000);
		chk("irq", 0, irq);
		rx(AF, 16'h4000);
		ce <= 0;
		hit(16'h2000);
		ce <= 1;
		rx(AF, 0);
		report_and_stop;
	end
endmodule

// [rfs_status_bank_props.sv]
// Bus and status-field assertions for the fault and output status bank
`timescale 1ns/100ps
module rfs_props (
	input logic aclk,
	input logic aresetn,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic irq,
	input logic [1:0] exciter_mode_control,
	input logic [13:0] parallel_output_bus
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire ar = s_axi_arvalid && s_axi_arready;
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before bready");
	AST_RANS: assert property (ar |=> s_axi_rvalid)
		else $error("no read answer one cycle after address");
	AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	AST_MODE: assert property (ar && s_axi_araddr == 8'h40 && $stable(exciter_mode_control)
		|=> s_axi_rdata[9] == $past(exciter_mode_control == 2'b11)) else $error("exciter disabled bit wrong");
	AST_PAR: assert property (ar && s_axi_araddr == 8'h44 && $stable(parallel_output_bus)
		|=> s_axi_rdata[14] == ^$past(parallel_output_bus)) else $error("parity bit wrong");
	AST_RSV: assert property (ar && (s_axi_araddr == 8'h44 || s_axi_araddr == 8'h48) |=> !s_axi_rdata[15])
		else $error("reserved bit 15 set");
	AST_A12: assert property (ar && s_axi_araddr == 8'h44 |=> !s_axi_rdata[12])
		else $error("angle bit 12 set");
	AST_UNMAP: assert property (ar && s_axi_araddr == 8'h4c |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	cover property (ar && s_axi_araddr == 8'h40);
	cover property ($rose(irq));
	cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind rfs_status_bank rfs_props chk (.*);
